//--- serial_port_pkg.sv
// Purpose: Shared constants and types for the three-wire serial control port
// Assumes: Register window 0x00..0x34, byte wide, one instruction format
// Notes:   Control and status are plain ports; no register bus

package serial_port_pkg;

  // ==========================================================
  // Sizes
  localparam int ADDR_W = 13;
  localparam int IDX_W = 6;
  localparam int INSTR_W = 16;
  localparam int NUM_REGS = 53;

  // ==========================================================
  // Register addresses and fields
  localparam logic [12:0] ADDR_PORT_CTRL = 13'h0000;
  localparam logic [12:0] ADDR_READBACK = 13'h0004;
  localparam logic [12:0] ADDR_UPDATE = 13'h0005;
  localparam logic [12:0] ADDR_LAST = 13'h0034;
  localparam logic [12:0] ADDR_STEP = 13'h0001;
  localparam int BIT_LSB_FIRST = 6;
  localparam int BIT_READBACK = 0;
  localparam int BIT_UPDATE = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PORT_CTRL_RESET = 8'h18;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // Instruction decode and counters
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [1:0] LEFT_NONE = 2'h0;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA = 2'b01,
    ST_DONE = 2'b11
  } port_state_t;

  typedef struct packed {
    logic read_write_flag_bit;
    logic [1:0] length_code;
    logic [12:0] start_register_address;
  } instr_t;

  typedef logic [NUM_REGS-1:0][7:0] reg_bank_t;

endpackage

//--- serial_control_port.sv
// Purpose: Target end of the three-wire serial control port
// Assumes: SCLK and CS_N come from the host; SCLK may stop between frames
// Notes:   Shadow and active banks live on SCLK; active copy crosses to CLK
`timescale 1ns/1ns
`default_nettype none

module serial_control_port (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE,
  output serial_port_pkg::reg_bank_t ACTIVE_REGS,
  output logic UPDATE_DONE,
  output logic LSB_FIRST
);

  // ==========================================================
  // Link-side state (SCLK domain)
  serial_port_pkg::port_state_t state_q, state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] shift_q, shift_d;
  serial_port_pkg::instr_t instr_q, instr_d;
  logic [12:0] addr_q, addr_d;
  logic [1:0] left_q, left_d;
  serial_port_pkg::reg_bank_t shadow_q, shadow_d;
  serial_port_pkg::reg_bank_t active_q, active_d;
  logic upd_tgl_q, upd_tgl_d;
  logic gap_q;
  logic gap_rst;

  // Helpers for the rising edge process
  localparam int IDX_W_C = serial_port_pkg::IDX_W;
  logic lsb_mode;
  logic fresh;
  serial_port_pkg::port_state_t st;
  logic [3:0] cnt;
  logic [15:0] sh;
  logic [15:0] sh_next;
  logic [7:0] byte_in;
  logic [IDX_W_C-1:0] wr_idx;

  // Read drive helpers (falling edge)
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;
  logic oe_rst_n;
  logic [7:0] rd_byte;
  logic [2:0] rd_pos;
  logic readback_shadow;

  // CLK domain crossing state
  logic upd_s1_q, upd_s2_q, upd_s3_q;
  serial_port_pkg::reg_bank_t act_out_q, act_out_d;
  logic done_q, done_d;
  logic lsb_out_q, lsb_out_d;

  // Bit order and readback source follow the active bank
  assign lsb_mode = active_q[serial_port_pkg::ADDR_PORT_CTRL[IDX_W_C-1:0]]
                            [serial_port_pkg::BIT_LSB_FIRST];
  assign readback_shadow =
    active_q[serial_port_pkg::ADDR_READBACK[IDX_W_C-1:0]]
            [serial_port_pkg::BIT_READBACK];

  // ==========================================================
  // Chip select gap flag
  // Set asynchronously whenever CS_N is high, cleared by the first SCLK
  // rise with CS_N low; lets a stall be seen even with SCLK stopped.
  assign gap_rst = CS_N | ~RST_N;

  always_ff @(posedge SCLK or posedge gap_rst) begin
    if (gap_rst) begin
      gap_q <= 1'b1;
    end else begin
      gap_q <= 1'b0;
    end
  end

  // ==========================================================
  // Next-value logic for shifting, decode, address and buffers
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    instr_d = instr_q;
    addr_d = addr_q;
    left_d = left_q;
    shadow_d = shadow_q;
    active_d = active_q;
    upd_tgl_d = upd_tgl_q;
    fresh = 1'b0;
    st = state_q;
    cnt = bit_cnt_q;
    sh = shift_q;
    sh_next = shift_q;
    byte_in = shift_q[7:0];
    wr_idx = addr_q[IDX_W_C-1:0];
    // Nothing moves while chip select is high
    if (!CS_N) begin
      // A gap off a byte boundary, after completion or in a stream restarts
      if (gap_q && ((bit_cnt_q[2:0] != serial_port_pkg::BYTE_FIRST_BIT) ||
                    (state_q == serial_port_pkg::ST_DONE) ||
                    (state_q == serial_port_pkg::ST_DATA &&
                     instr_q.length_code == serial_port_pkg::LEN_STREAM)))
      begin
        fresh = 1'b1;
      end
      // Byte-boundary stalls outside a stream and before completion keep all progress
      st = fresh ? serial_port_pkg::ST_INSTR : state_q;
      cnt = fresh ? 4'h0 : bit_cnt_q;
      sh = fresh ? 16'h0000 : shift_q;
      // Sample the data pin on the rising edge in the chosen order
      sh_next = lsb_mode ? {SDIO_I, sh[15:1]} : {sh[14:0], SDIO_I};
      byte_in = lsb_mode ? sh_next[15:8] : sh_next[7:0];
      state_d = st;
      shift_d = sh_next;
      case (st)
        serial_port_pkg::ST_INSTR: begin
          bit_cnt_d = cnt + 4'h1;
          if (cnt == serial_port_pkg::INSTR_LAST_BIT) begin
            instr_d = serial_port_pkg::instr_t'(sh_next);
            addr_d = sh_next[12:0];
            left_d = sh_next[14:13];
            state_d = serial_port_pkg::ST_DATA;
            bit_cnt_d = 4'h0;
          end
        end
        serial_port_pkg::ST_DATA: begin
          bit_cnt_d = {1'b0, cnt[2:0] + 3'h1};
          if (cnt[2:0] == serial_port_pkg::BYTE_LAST_BIT) begin
            bit_cnt_d = 4'h0;
            wr_idx = addr_q[IDX_W_C-1:0];
            // Completed write byte goes to the shadow bank
            if (!instr_q.read_write_flag_bit &&
                addr_q <= serial_port_pkg::ADDR_LAST) begin
              shadow_d[wr_idx] = byte_in;
              if (addr_q == serial_port_pkg::ADDR_UPDATE) begin
                // Update bit clears itself after copying every byte
                shadow_d[wr_idx][serial_port_pkg::BIT_UPDATE] = 1'b0;
                if (byte_in[serial_port_pkg::BIT_UPDATE]) begin
                  active_d = shadow_q;
                  upd_tgl_d = ~upd_tgl_q;
                end
              end
            end
            // Step to the next address with no skipping
            if (lsb_mode) begin
              addr_d = addr_q + serial_port_pkg::ADDR_STEP;
            end else begin
              addr_d = addr_q - serial_port_pkg::ADDR_STEP;
            end
            // Fixed lengths count down; streaming runs on
            if (instr_q.length_code != serial_port_pkg::LEN_STREAM) begin
              if (left_q == serial_port_pkg::LEFT_NONE) begin
                state_d = serial_port_pkg::ST_DONE;
              end else begin
                left_d = left_q - 2'h1;
              end
            end else begin
              state_d = serial_port_pkg::ST_DATA;
            end
          end
        end
        default: begin
          state_d = serial_port_pkg::ST_DONE;
          bit_cnt_d = bit_cnt_q;
          shift_d = shift_q;
        end
      endcase
    end
  end

  // Registers of the rising edge process
  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= serial_port_pkg::ST_INSTR;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
      instr_q <= '0;
      addr_q <= 13'h0000;
      left_q <= 2'h0;
      shadow_q <= {serial_port_pkg::NUM_REGS{serial_port_pkg::REG_RESET}};
      shadow_q[serial_port_pkg::ADDR_PORT_CTRL[IDX_W_C-1:0]] <=
        serial_port_pkg::PORT_CTRL_RESET;
      active_q <= {serial_port_pkg::NUM_REGS{serial_port_pkg::REG_RESET}};
      active_q[serial_port_pkg::ADDR_PORT_CTRL[IDX_W_C-1:0]] <=
        serial_port_pkg::PORT_CTRL_RESET;
      upd_tgl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      instr_q <= instr_d;
      addr_q <= addr_d;
      left_q <= left_d;
      shadow_q <= shadow_d;
      active_q <= active_d;
      upd_tgl_q <= upd_tgl_d;
    end
  end

  // ==========================================================
  // Read data drive on the falling edge
  // Released asynchronously the moment chip select rises.
  assign oe_rst_n = RST_N & ~CS_N;

  always_comb begin
    rd_pos = lsb_mode ? bit_cnt_q[2:0]
                      : (serial_port_pkg::BYTE_LAST_BIT - bit_cnt_q[2:0]);
    rd_byte = serial_port_pkg::REG_RESET;
    // Unmapped addresses read back as zero
    if (addr_q <= serial_port_pkg::ADDR_LAST) begin
      rd_byte = readback_shadow ? shadow_q[addr_q[IDX_W_C-1:0]]
                                : active_q[addr_q[IDX_W_C-1:0]];
    end
    oe_d = (state_q == serial_port_pkg::ST_DATA) &&
           instr_q.read_write_flag_bit;
    sdo_d = rd_byte[rd_pos];
  end

  always_ff @(negedge SCLK or negedge oe_rst_n) begin
    if (!oe_rst_n) begin
      oe_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
      sdo_q <= sdo_d;
    end
  end

  // ==========================================================
  // Update event into the CLK domain
  // Toggle passes two flops; the active bank is stable until the next
  // update, so it is sampled only after the event arrives.
  always_comb begin
    act_out_d = act_out_q;
    done_d = 1'b0;
    if (upd_s2_q ^ upd_s3_q) begin
      act_out_d = active_q;
      done_d = 1'b1;
    end
    lsb_out_d = act_out_q[serial_port_pkg::ADDR_PORT_CTRL[IDX_W_C-1:0]]
                         [serial_port_pkg::BIT_LSB_FIRST];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      upd_s1_q <= 1'b0;
      upd_s2_q <= 1'b0;
      upd_s3_q <= 1'b0;
      act_out_q <= {serial_port_pkg::NUM_REGS{serial_port_pkg::REG_RESET}};
      act_out_q[serial_port_pkg::ADDR_PORT_CTRL[IDX_W_C-1:0]] <=
        serial_port_pkg::PORT_CTRL_RESET;
      done_q <= 1'b0;
      lsb_out_q <= 1'b0;
    end else begin
      upd_s1_q <= upd_tgl_q;
      upd_s2_q <= upd_s1_q;
      upd_s3_q <= upd_s2_q;
      act_out_q <= act_out_d;
      done_q <= done_d;
      lsb_out_q <= lsb_out_d;
    end
  end

  // Outputs straight from flops
  assign SDIO_O = sdo_q;
  assign SDIO_OE = oe_q;
  assign ACTIVE_REGS = act_out_q;
  assign UPDATE_DONE = done_q;
  assign LSB_FIRST = lsb_out_q;

endmodule

`default_nettype wire

//--- serial_port_monitor.sv
// Purpose: Port checks for the serial control port
// Assumes: Sees only the ports of the top module
// Notes:   Attached to every serial_control_port
`timescale 1ns/1ns
`default_nettype none
module serial_port_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_OE,
  input wire serial_port_pkg::reg_bank_t ACTIVE_REGS,
  input wire logic UPDATE_DONE,
  input wire logic LSB_FIRST
);
  // ================================================
  // System clock checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  AST_OE_CS: assert property (CS_N |-> !SDIO_OE)
    else $error("pin driven while deselected");
  AST_ACT_HOLD: assert property (
    !UPDATE_DONE |-> $stable(ACTIVE_REGS))
    else $error("active bank moved alone");
  AST_DONE_ONE: assert property (
    UPDATE_DONE |=> !UPDATE_DONE [*8])
    else $error("update pulse too long");
  AST_SELF_CLR: assert property (!ACTIVE_REGS[5][0])
    else $error("update bit stuck");
  AST_LSB_MIR: assert property (
    LSB_FIRST == $past(ACTIVE_REGS[0][6]))
    else $error("order flag mismatch");
  AST_LSB_UPD: assert property (
    $changed(LSB_FIRST) |-> $past(UPDATE_DONE))
    else $error("order changed without update");
  AST_RST_VAL: assert property ($rose(RST_N) |->
    ACTIVE_REGS[0] == serial_port_pkg::PORT_CTRL_RESET && !LSB_FIRST)
    else $error("bad reset state");
  // ================================================
  // Serial clock checks, then covers on both clocks
  AST_IDLE_SCLK: assert property (
    @(posedge SCLK) disable iff (!RST_N) CS_N |-> !SDIO_OE)
    else $error("drive outside frame");
  AST_OE_SEL: assert property (
    @(negedge SCLK) disable iff (!RST_N) $rose(SDIO_OE) |-> !CS_N)
    else $error("drive start while deselected");
  CV_UPD: cover property (UPDATE_DONE);
  CV_READ: cover property (@(negedge SCLK) $rose(SDIO_OE));
  CV_LSB: cover property ($rose(LSB_FIRST));
endmodule
bind serial_control_port serial_port_monitor i_serial_port_monitor (
  .CLK(CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N),
  .SDIO_OE(SDIO_OE), .ACTIVE_REGS(ACTIVE_REGS),
  .UPDATE_DONE(UPDATE_DONE), .LSB_FIRST(LSB_FIRST));
`default_nettype wire

//--- serial_host_model.sv
// Purpose: Host that drives the serial control port
// Assumes: SCLK idles low and runs only inside frames
// Notes:   A released pin shows the inverse of the last host bit
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  output logic SCLK,
  output logic CS_N,
  output logic SDIO_I,
  input wire logic SDIO_O,
  input wire logic SDIO_OE
);
  logic hbit = 1'b0;
  logic hoe = 1'b0;
  logic lsb = 1'b0;
  logic [31:0] r;
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
  end
  // Resolved data pin level
  assign SDIO_I = SDIO_OE ? SDIO_O : (hoe ? hbit : ~hbit);
  // ================================================
  // Bit shifting
  task automatic shift(input logic [31:0] v, input int n,
                       input logic drv, output logic [31:0] q);
    int k;
    q = 32'h0;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      hoe = drv;
      hbit = v[k];
      #15 SCLK = 1'b1;
      q[k] = SDIO_I;
      #15 SCLK = 1'b0;
    end
    hoe = 1'b0;
  endtask
  // One selection holding n driven bits
  task automatic seg(input logic [31:0] v, input int n);
    CS_N = 1'b0;
    #15;
    shift(v, n, 1'b1, r);
    #15 CS_N = 1'b1;
    #30;
  endtask
  // Whole frame: instruction, then nb data bytes
  task automatic frame(input logic rd, input logic [1:0] len,
    input logic [12:0] a, input logic [31:0] v, input int nb,
    output logic [31:0] q);
    CS_N = 1'b0;
    #15;
    shift({16'h0, rd, len, a}, 16, 1'b1, q);
    shift(v, nb * 8, !rd, q);
    #15 CS_N = 1'b1;
    #30;
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for the serial control port
// Assumes: Host model owns SCLK, CS_N and the data pin
// Notes:   Expected register bytes follow from the address order
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic sclk, cs_n, sdio_i, sdio_o, sdio_oe, update_done, lsb_first;
  serial_port_pkg::reg_bank_t active_regs;
  logic [31:0] r;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  serial_control_port i_serial_control_port (.CLK(clk), .RST_N(rst_n),
    .SCLK(sclk), .CS_N(cs_n), .SDIO_I(sdio_i), .SDIO_O(sdio_o),
    .SDIO_OE(sdio_oe), .ACTIVE_REGS(active_regs),
    .UPDATE_DONE(update_done), .LSB_FIRST(lsb_first));
  serial_host_model i_serial_host_model (.SCLK(sclk), .CS_N(cs_n),
    .SDIO_I(sdio_i), .SDIO_O(sdio_o), .SDIO_OE(sdio_oe));
  // ================================================
  // Clock and cycle ceiling
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  // ================================================
  // Access and compare tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic rchk(input int i, input logic [7:0] e);
    chk({24'h0, active_regs[i]}, {24'h0, e});
  endtask
  task automatic wr(input logic [1:0] len, input logic [12:0] a,
                    input logic [31:0] v, input int nb);
    i_serial_host_model.frame(1'b0, len, a, v, nb, r);
  endtask
  task automatic rdc(input logic [1:0] len, input logic [12:0] a,
                     input int nb, input logic [31:0] e);
    i_serial_host_model.frame(1'b1, len, a, 32'h0, nb, r);
    chk(r, e);
  endtask
  task automatic upd();
    wr(2'h0, serial_port_pkg::ADDR_UPDATE, 32'h1, 1);
    for (int n = 0; n < 20 && update_done !== 1'b1; n++) @(negedge clk);
    chk({31'h0, update_done}, 32'h1);
  endtask
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #5 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #5;
    rchk(0, serial_port_pkg::PORT_CTRL_RESET);
    // Three bytes to 0x0c with stalls after instruction and a byte
    i_serial_host_model.seg(32'h400c, 16);
    i_serial_host_model.seg(32'h11, 8);
    i_serial_host_model.seg(32'h2233, 16);
    rchk(12, 8'h00);
    upd();
    rchk(12, 8'h11);
    rchk(11, 8'h22);
    rchk(10, 8'h33);
    // Deselect mid-byte, then a stall aborted by three clocks
    i_serial_host_model.seg(32'h2010f, 20);
    i_serial_host_model.seg(32'h0011, 16);
    i_serial_host_model.seg(32'h7, 3);
    upd();
    rchk(16, 8'h00);
    rchk(17, 8'h00);
    rdc(2'h3, 13'h000c, 4, 32'h11223300);
    // Readback of active, then of shadow bytes
    wr(2'h0, 13'h000c, 32'h5a, 1);
    rdc(2'h0, 13'h000c, 1, 32'h11);
    wr(2'h0, serial_port_pkg::ADDR_READBACK, 32'h1, 1);
    upd();
    rchk(12, 8'h5a);
    wr(2'h0, 13'h000c, 32'h77, 1);
    rdc(2'h0, 13'h000c, 1, 32'h77);
    // Switch to LSB first and write upward
    wr(2'h0, serial_port_pkg::ADDR_PORT_CTRL, 32'h58, 1);
    upd();
    @(negedge clk);
    chk({31'h0, lsb_first}, 32'h1);
    i_serial_host_model.lsb = 1'b1;
    wr(2'h1, 13'h0020, 32'hbbaa, 2);
    upd();
    rchk(32, 8'haa);
    rchk(33, 8'hbb);
    conclude();
  end
endmodule
`default_nettype wire
